// file: swdt_top.sv
// system watchdog timer top: service-call decode, countdown, expiry action
// assumes command fields arrive synchronous to SYS_CLK as a strobe
// assumes UNIT_SEL and ACT_SEL are static configuration levels
`timescale 1ns/10ps
`include "swdt_consts.svh"
module swdt_top
  import swdt_pkg::*;
#(
  parameter int unsigned TICK_CYC = `SWDT_TICK_CYC, // cycles per ms
  parameter int unsigned SEC_MS = `SWDT_UNIT_SEC_MS, // ms per second
  parameter int unsigned MIN_MS = `SWDT_UNIT_MIN_MS  // ms per minute
) (
  input wire logic SYS_CLK,          // 250 MHz system clock
  input wire logic RST,              // async reset, high
  input wire logic CMD_VALID,        // service call strobe
  input wire swdt_cmd_s CMD,         // function, sub, operand
  input wire swdt_unit_e UNIT_SEL,   // configured count unit
  input wire swdt_act_e ACT_SEL,     // configured expiry action
  output logic CMD_ACK,              // call accepted pulse
  output logic ARMED,                // watchdog counting
  output logic [7:0] COUNT,          // remaining units
  output logic SYS_RESET_REQ,        // cold boot request pulse
  output logic NMI_REQ               // nmi request pulse
);
  ////////////////////////////////////////////////////////////////////////
  // decode
  // only the period-setting call exists here; every other function or
  // sub-function code belongs to other firmware services and is ignored
  // match one call against the period-setting command
  function automatic logic is_set_period(input swdt_cmd_s c);
    return c.func == `SWDT_FUNC_CODE && c.sub == `SWDT_SUB_SET_PERIOD;
  endfunction
  wire load = CMD_VALID && is_set_period(CMD);
  wire load_zero = load && (CMD.operand == 8'h00);
  ////////////////////////////////////////////////////////////////////////
  // parameter checks
  // tick counter is sized from the divide ratio, so the full default
  // ratio fits; a zero ratio would wrap to a tick every second cycle and is refused
  localparam int unsigned TICK_W = (TICK_CYC > 1) ? $clog2(TICK_CYC) : 1;
  if (TICK_CYC == 0) begin : g_bad_tick
    $error("tick divider ratio must be nonzero");
  end
  if (`SWDT_CNT_W != 8) begin : g_bad_cnt
    $error("count width must stay eight bits");
  end
  ////////////////////////////////////////////////////////////////////////
  // millisecond tick
  logic [TICK_W-1:0] tick_r; // cycles within one ms
  logic [TICK_W-1:0] tick_nxt; // next tick count
  // last cycle of each millisecond; one-cycle enable for the divider
  wire tick = (tick_r == TICK_W'(TICK_CYC - 1));
  // a load realigns the millisecond phase as well as the unit phase, so
  // the first unit after a refresh is never short by a partial ms
  assign tick_nxt = (tick || load) ? '0 : tick_r + TICK_W'(1);
  // tick counter
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) tick_r <= '0;
    else tick_r <= tick_nxt;
  end
  // unit pulse; unit follows the configuration, not a fixed figure
  // the divider restarts with every load so a refresh buys a full unit
  logic unit_pulse; // one per selected unit
  swdt_unit_div #(.SEC_MS(SEC_MS), .MIN_MS(MIN_MS)) u_div (
    .clk(SYS_CLK),
    .rst(RST),
    .restart(load),
    .tick(tick),
    .unit(UNIT_SEL),
    .unit_pulse(unit_pulse)
  );
  ////////////////////////////////////////////////////////////////////////
  // countdown; a reload always wins over a decrement in the same cycle
  logic [`SWDT_CNT_W-1:0] cnt_r; // remaining units
  logic [`SWDT_CNT_W-1:0] cnt_nxt;
  logic armed_r; // running
  logic armed_nxt;
  logic rst_req_r; // reset pulse
  logic nmi_req_r; // nmi pulse
  logic ack_r; // call accepted, one cycle late
  // last unit pulse of a run; a load in the same cycle cancels it, so a
  // refresh that lands on the final unit still saves the system
  wire expire = armed_r && !load && unit_pulse && (cnt_r == 8'h01);
  assign cnt_nxt = load ? CMD.operand :
                   (armed_r && unit_pulse) ? cnt_r - 8'h01 :
                   cnt_r;
  // zero load disarms; expiry disarms so it fires once
  assign armed_nxt = load ? !load_zero :
                     expire ? 1'b0 : armed_r;
  // count and run state; reset leaves the watchdog off until a load,
  // so a board that never starts the service cannot reset itself
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      cnt_r <= `SWDT_CNT_RESET;
      armed_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      armed_r <= armed_nxt;
    end
  end
  // expiry routing and call ack, registered
  // limitation: ACT_SEL is read at expiry, not at load time
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      rst_req_r <= 1'b0;
      nmi_req_r <= 1'b0;
      ack_r <= 1'b0;
    end else begin
      rst_req_r <= expire && (ACT_SEL == SWDT_ACT_RESET);
      nmi_req_r <= expire && (ACT_SEL == SWDT_ACT_NMI);
      ack_r <= load;
    end
  end
  // outputs straight from flip-flops; no decode between flop and pin
  assign CMD_ACK = ack_r;
  assign ARMED = armed_r;
  assign COUNT = cnt_r;
  assign SYS_RESET_REQ = rst_req_r;
  assign NMI_REQ = nmi_req_r;
  ////////////////////////////////////////////////////////////////////////
  // checks
  // all on SYS_CLK and quiet during reset; they watch internal nets as well as
  // the outputs, so a broken decode or counter shows up at its source
  // a matching call lands its operand in the count
  AST_LOAD_VALUE: assert property (
    @(posedge SYS_CLK) disable iff (RST)
    load |=> COUNT == $past(CMD.operand))
    else $error("load missed");
  // a matching call is answered on the next cycle
  AST_ACK: assert property (
    @(posedge SYS_CLK) disable iff (RST)
    load |=> CMD_ACK)
    else $error("call not acknowledged");
  // any other call, or none, leaves the ack low
  AST_NO_ACK: assert property (
    @(posedge SYS_CLK) disable iff (RST)
    !load |=> !CMD_ACK)
    else $error("stray acknowledge");
  // the divider only steps on a millisecond tick
  AST_UNIT_ON_TICK: assert property (
    @(posedge SYS_CLK) disable iff (RST)
    unit_pulse |-> tick)
    else $error("unit pulse off tick");
  // a nonzero load starts the run
  AST_NZ_ARM: assert property (
    @(posedge SYS_CLK) disable iff (RST)
    (load && !load_zero) |=> ARMED)
    else $error("not armed");
  // one unit pulse takes exactly one off the count
  AST_DEC: assert property (
    @(posedge SYS_CLK) disable iff (RST)
    (armed_r && unit_pulse && !load && cnt_r > 8'h01) |=>
    COUNT == $past(cnt_r) - 8'h01) else $error("bad decrement");
  // between unit pulses the count and run state hold still
  AST_HOLD: assert property (
    @(posedge SYS_CLK) disable iff (RST)
    (armed_r && !load && !unit_pulse) |=> ARMED && $stable(COUNT))
    else $error("count moved off a unit pulse");
  // the last unit fires an action and ends the run
  AST_EXPIRE: assert property (
    @(posedge SYS_CLK) disable iff (RST)
    expire |=> (SYS_RESET_REQ || NMI_REQ) && !ARMED)
    else $error("expiry lost");
  // never both actions at once
  AST_ONE_ACT: assert property (
    @(posedge SYS_CLK) disable iff (RST)
    !(SYS_RESET_REQ && NMI_REQ))
    else $error("two actions");
  // cold reset when configured for it
  AST_ROUTE_RST: assert property (
    @(posedge SYS_CLK) disable iff (RST)
    (expire && ACT_SEL == SWDT_ACT_RESET) |=> SYS_RESET_REQ)
    else $error("reset action not routed");
  // nmi when configured for it
  AST_ROUTE_NMI: assert property (
    @(posedge SYS_CLK) disable iff (RST)
    (expire && ACT_SEL == SWDT_ACT_NMI) |=> NMI_REQ)
    else $error("nmi action not routed");
  // a reload on a running timer never fires
  AST_RELOAD: assert property (
    @(posedge SYS_CLK) disable iff (RST)
    (load && armed_r) |=> !SYS_RESET_REQ && !NMI_REQ)
    else $error("reload did not refresh");
  // a zero load stops the run
  AST_ZERO_DISARM: assert property (
    @(posedge SYS_CLK) disable iff (RST)
    load_zero |=> !ARMED)
    else $error("zero load left armed");
  // a stopped timer raises no action
  AST_QUIET_DISARMED: assert property (
    @(posedge SYS_CLK) disable iff (RST)
    !armed_r |=> !SYS_RESET_REQ && !NMI_REQ)
    else $error("action while disarmed");
  // nothing moves while off and not loaded
  AST_IDLE_QUIET: assert property (
    @(posedge SYS_CLK) disable iff (RST)
    (!armed_r && !load) |=> !ARMED && $stable(COUNT))
    else $error("idle changed");
  // an idle timer always shows a zero count
  AST_IDLE_ZERO: assert property (
    @(posedge SYS_CLK) disable iff (RST)
    !ARMED |-> COUNT == 8'h00)
    else $error("idle count not zero");
  // each action is a single pulse
  AST_ONCE: assert property (
    @(posedge SYS_CLK) disable iff (RST)
    (SYS_RESET_REQ || NMI_REQ) |=> !(SYS_RESET_REQ || NMI_REQ))
    else $error("action repeated");
  // a running timer never shows zero units left
  AST_ARMED_NZ: assert property (
    @(posedge SYS_CLK) disable iff (RST)
    ARMED |-> COUNT != 8'h00)
    else $error("armed with zero count");
endmodule

// file: swdt_consts.svh
// constants for the system watchdog timer: command codes, widths, timing
// assumes a 250 MHz system clock; included by the package and modules
`ifndef SWDT_CONSTS_SVH
`define SWDT_CONSTS_SVH
`define SWDT_FUNC_CODE 8'h6f
`define SWDT_SUB_SET_PERIOD 8'h02
`define SWDT_CNT_W 8
`define SWDT_CNT_RESET 8'h00
`define SWDT_CLK_HZ 250000000
`define SWDT_UNIT_SEC_MS 1000
`define SWDT_UNIT_MIN_MS 60000
`define SWDT_TICK_MS 1
`define SWDT_TICK_CYC ((`SWDT_CLK_HZ / 1000) * `SWDT_TICK_MS)
`endif

// file: swdt_pkg.sv
// types for the system watchdog timer
// assumes swdt_consts.svh is on the include path
`include "swdt_consts.svh"
package swdt_pkg;
  // one service call as it arrives from the host
  typedef struct packed {
    logic [7:0] func;     // function code
    logic [7:0] sub;      // sub-function
    logic [7:0] operand;  // time-out value
  } swdt_cmd_s;
  // expiry action choice
  typedef enum logic [0:0] {
    SWDT_ACT_RESET = 1'b0,
    SWDT_ACT_NMI   = 1'b1
  } swdt_act_e;
  // count unit choice
  typedef enum logic [0:0] {
    SWDT_UNIT_SEC = 1'b0,
    SWDT_UNIT_MIN = 1'b1
  } swdt_unit_e;
endpackage

// file: swdt_unit_div.sv
// unit divider: one-cycle pulse per selected count unit
// assumes a tick enable of one per millisecond from the parent
`timescale 1ns/10ps
`include "swdt_consts.svh"
module swdt_unit_div
  import swdt_pkg::*;
#(
  parameter int unsigned SEC_MS = `SWDT_UNIT_SEC_MS, // ticks per second
  parameter int unsigned MIN_MS = `SWDT_UNIT_MIN_MS  // ticks per minute
) (
  input wire logic clk,         // system clock
  input wire logic rst,         // async reset, high
  input wire logic restart,     // realign phase on reload
  input wire logic tick,        // millisecond enable
  input wire swdt_unit_e unit,  // selected unit
  output logic unit_pulse       // one pulse per unit
);
  logic [15:0] ms_r;  // ticks in the current unit
  logic [15:0] ms_nxt;
  wire [15:0] ms_top = (unit == SWDT_UNIT_MIN) ? 16'(MIN_MS - 1) :
                                                 16'(SEC_MS - 1);
  wire at_top = tick && (ms_r >= ms_top);
  // refuse ratios that the 16-bit phase counter cannot serve
  if (SEC_MS == 0 || MIN_MS == 0) begin : g_bad_zero
    $error("unit divider ratio must be nonzero");
  end
  if (SEC_MS > 65536 || MIN_MS > 65536) begin : g_bad_wide
    $error("unit divider ratio too wide");
  end
  // wrap at unit boundary; restart gives each reload a full first unit
  assign ms_nxt = restart ? 16'h0000 : at_top ? 16'h0000 :
                  tick ? ms_r + 16'h0001 : ms_r;
  assign unit_pulse = at_top && !restart;
  // milliseconds counter
  always_ff @(posedge clk or posedge rst) begin
    if (rst) ms_r <= 16'h0000;
    else ms_r <= ms_nxt;
  end
endmodule

// file: swdt_host.sv
// host software model: issues watchdog service calls
// assumes tb_top calls its task; drives after the rising edge
`timescale 1ns/10ps
module swdt_host
  import swdt_pkg::*;
(
  input wire logic clk, // system clock
  output logic valid, // call strobe
  output swdt_cmd_s cmd // call fields
);
  initial begin
    valid = 1'b0;
    cmd = '0;
  end
  // one-cycle call; fields inverted after so stale data never lingers
  task automatic call(input logic [7:0] f, s, op);
    @(posedge clk);
    valid <= 1'b1;
    cmd <= '{f, s, op};
    @(posedge clk);
    valid <= 1'b0;
    cmd <= ~cmd;
  endtask
endmodule

// file: tb_top.sv
// watchdog bench: load, expiry, refresh, disable, refused calls
// assumes short sim params: unit of seconds 6 cycles, minutes 10
`timescale 1ns/10ps
module tb_top;
  import swdt_pkg::*;
  logic clk, rst, v, ack, armed, rreq, nreq;
  swdt_cmd_s cmd;
  swdt_unit_e unit;
  swdt_act_e act;
  logic [7:0] cnt;
  int mismatches = 0, check_count = 0, cyc = 0, fires = 0;
  swdt_host u_host (.clk(clk), .valid(v), .cmd(cmd));
  swdt_top #(.TICK_CYC(2), .SEC_MS(3), .MIN_MS(5)) u_dut (.SYS_CLK(clk),
    .RST(rst), .CMD_VALID(v), .CMD(cmd), .UNIT_SEL(unit), .ACT_SEL(act),
    .CMD_ACK(ack), .ARMED(armed), .COUNT(cnt), .SYS_RESET_REQ(rreq),
    .NMI_REQ(nreq));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic chk(input string n, input logic [7:0] e, g);
    check_count++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // hang guard; also counts every expiry pulse seen
  always @(posedge clk) begin
    cyc++;
    if (rreq === 1'b1 || nreq === 1'b1) fires++;
    if (cyc == 3000) begin
      mismatches++;
      end_of_test();
    end
  end
  task automatic load(input logic [7:0] op);
    u_host.call(8'h6f, 8'h02, op);
    #1;
    chk("ack", 8'h01, {7'h0, ack});
    chk("count", op, cnt);
    chk("armed", {7'h0, op != 8'h00}, {7'h0, armed});
    @(posedge clk);
    #1;
    chk("ack_drop", 8'h00, {7'h0, ack});
  endtask
  // cycles until an expiry pulse, 300 if none
  task automatic wait_exp(output int n);
    n = 0;
    while (!(rreq === 1'b1 || nreq === 1'b1) && n < 300) begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask
  task automatic expire(input swdt_unit_e u, input swdt_act_e a,
                        input logic [7:0] op, input int upc);
    int n;
    @(posedge clk);
    unit <= u;
    act <= a;
    load(op);
    wait_exp(n);
    // load() already spent one cycle of the first unit on the ack drop
    chk("span", 8'(op * upc - 1), n[7:0]);
    chk("rst_req", {7'h0, a == SWDT_ACT_RESET}, {7'h0, rreq});
    chk("nmi_req", {7'h0, a == SWDT_ACT_NMI}, {7'h0, nreq});
    chk("count_end", 8'h00, cnt);
    chk("disarmed", 8'h00, {7'h0, armed});
    @(posedge clk);
    #1;
    chk("one_pulse", 8'h00, {6'h0, rreq, nreq});
  endtask
  // reload every 10 cycles against a 12-cycle span, then switch off
  task automatic refresh;
    int n, f0;
    f0 = fires;
    repeat (6) begin
      load(8'h02);
      repeat (7) @(posedge clk);
    end
    chk("no_fire", f0[7:0], fires[7:0]);
    load(8'h00);
    wait_exp(n);
    chk("stopped", 8'h01, {7'h0, n == 300});
  endtask
  // reset in mid-count: outputs clear at once and nothing fires later
  task automatic mid_reset;
    int n;
    load(8'h05);
    repeat (10) @(posedge clk);
    rst <= 1'b1;
    #1;
    chk("mid_rst", 8'h00, {5'h0, ack, armed, rreq | nreq} | cnt);
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    wait_exp(n);
    chk("rst_quiet", 8'h01, {7'h0, n == 300});
  endtask
  // wrong function or sub-function is ignored
  task automatic refused;
    u_host.call(8'h6e, 8'h02, 8'h05);
    #1;
    chk("no_ack_f", 8'h00, {7'h0, ack} | cnt);
    u_host.call(8'h6f, 8'h01, 8'h05);
    #1;
    chk("no_ack_s", 8'h00, {7'h0, ack} | cnt);
  endtask
  initial begin
    rst = 1'b1;
    unit = SWDT_UNIT_SEC;
    act = SWDT_ACT_RESET;
    repeat (5) @(posedge clk);
    #1;
    chk("rst_out", 8'h00, {4'h0, ack, armed, rreq, nreq} | cnt);
    @(posedge clk) rst <= 1'b0;
    refused();
    expire(SWDT_UNIT_SEC, SWDT_ACT_RESET, 8'h03, 6);
    expire(SWDT_UNIT_MIN, SWDT_ACT_NMI, 8'h02, 10);
    expire(SWDT_UNIT_SEC, SWDT_ACT_NMI, 8'h01, 6);
    mid_reset();
    refresh();
    end_of_test();
  end
endmodule
